// ---- rtl/mifd_pkg.sv ----
// package for the instruction format decoder: constants and types
// =============================================================
package mifd_pkg;
  localparam int unsigned IW = 14;
  localparam int unsigned FW = 7;
  localparam int unsigned QPER = 4;
  localparam logic [1:0] Q_DECODE = 2'h0;
  localparam logic [1:0] Q_READ = 2'h1;
  localparam logic [1:0] Q_WRITE = 2'h3;
  localparam logic [1:0] CL_BYTE = 2'h0;
  localparam logic [1:0] CL_BIT = 2'h1;
  localparam logic [1:0] CL_JUMP = 2'h2;
  localparam logic [1:0] CL_LIT = 2'h3;
  localparam logic [13:0] W_NOP = 14'h0000;
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_RETFIE = 14'h0009;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_CLRWDT = 14'h0064;

  typedef enum logic [1:0] {
    MIFD_CLS_BYTE, MIFD_CLS_BIT, MIFD_CLS_LIT
  } mifd_class_t;

  typedef enum logic [4:0] {
    MIFD_OP_NOP, MIFD_OP_MOVWF, MIFD_OP_CLRW, MIFD_OP_CLRF, MIFD_OP_SUBWF,
    MIFD_OP_DECF, MIFD_OP_IORWF, MIFD_OP_ANDWF, MIFD_OP_XORWF,
    MIFD_OP_ADDWF, MIFD_OP_MOVF, MIFD_OP_COMF, MIFD_OP_INCF,
    MIFD_OP_DECFSZ, MIFD_OP_RRF, MIFD_OP_RLF, MIFD_OP_SWAPF,
    MIFD_OP_INCFSZ, MIFD_OP_BCF, MIFD_OP_BSF, MIFD_OP_BTFSC,
    MIFD_OP_BTFSS, MIFD_OP_CALL, MIFD_OP_GOTO, MIFD_OP_MOVLW,
    MIFD_OP_RETLW, MIFD_OP_IORLW, MIFD_OP_ANDLW, MIFD_OP_XORLW,
    MIFD_OP_SUBLW, MIFD_OP_ADDLW, MIFD_OP_CTRL
  } mifd_op_t;

  typedef struct packed {
    logic valid;
    mifd_class_t cls;
    mifd_op_t op;
    logic [FW-1:0] reg_sel;
    logic result_target;
    logic [2:0] pos_sel_in_octet;
    logic [7:0] imm8;
    logic [10:0] imm11;
    logic uses_file;
    logic writes_file;
    logic writes_acc;
    logic flow_change;
    logic cond_skip;
    logic is_ctrl;
  } mifd_dec_t;
endpackage

// ---- rtl/mifd_field_split.sv ----
// combinational split of one 14-bit word into class, opcode and operands
`timescale 1ns/100ps
`default_nettype none
module mifd_field_split (
  input wire logic [13:0] word,
  output var mifd_pkg::mifd_dec_t dec
);
  always_comb begin
    dec = '0;
    dec.valid = 1'b1;
    dec.reg_sel = word[6:0];
    dec.result_target = word[7];
    dec.pos_sel_in_octet = word[9:7];
    dec.imm8 = word[7:0];
    dec.imm11 = word[10:0];
    case (word[13:12])
      mifd_pkg::CL_BYTE: begin
        dec.cls = mifd_pkg::MIFD_CLS_BYTE;
        dec.uses_file = 1'b1;
        dec.writes_file = word[7];
        dec.writes_acc = ~word[7];
        case (word[11:8])
          4'h0: begin
            dec.uses_file = word[7];
            dec.writes_acc = 1'b0;
            if (word[7]) begin
              dec.op = mifd_pkg::MIFD_OP_MOVWF;
            end else if (word == mifd_pkg::W_RETURN ||
                         word == mifd_pkg::W_RETFIE) begin
              dec.op = mifd_pkg::MIFD_OP_CTRL;
              dec.is_ctrl = 1'b1;
              dec.flow_change = 1'b1;
            end else if (word == mifd_pkg::W_SLEEP ||
                         word == mifd_pkg::W_CLRWDT) begin
              dec.op = mifd_pkg::MIFD_OP_CTRL;
              dec.is_ctrl = 1'b1;
            end else begin
              dec.op = mifd_pkg::MIFD_OP_NOP;
            end
          end
          4'h1: begin
            // low seven bits ignored for the accumulator clear
            dec.op = word[7] ? mifd_pkg::MIFD_OP_CLRF :
                     mifd_pkg::MIFD_OP_CLRW;
            dec.uses_file = word[7];
            dec.writes_acc = ~word[7];
          end
          4'h2: dec.op = mifd_pkg::MIFD_OP_SUBWF;
          4'h3: dec.op = mifd_pkg::MIFD_OP_DECF;
          4'h4: dec.op = mifd_pkg::MIFD_OP_IORWF;
          4'h5: dec.op = mifd_pkg::MIFD_OP_ANDWF;
          4'h6: dec.op = mifd_pkg::MIFD_OP_XORWF;
          4'h7: dec.op = mifd_pkg::MIFD_OP_ADDWF;
          4'h8: dec.op = mifd_pkg::MIFD_OP_MOVF;
          4'h9: dec.op = mifd_pkg::MIFD_OP_COMF;
          4'hA: dec.op = mifd_pkg::MIFD_OP_INCF;
          4'hB: begin
            dec.op = mifd_pkg::MIFD_OP_DECFSZ;
            dec.cond_skip = 1'b1;
          end
          4'hC: dec.op = mifd_pkg::MIFD_OP_RRF;
          4'hD: dec.op = mifd_pkg::MIFD_OP_RLF;
          4'hE: dec.op = mifd_pkg::MIFD_OP_SWAPF;
          default: begin
            dec.op = mifd_pkg::MIFD_OP_INCFSZ;
            dec.cond_skip = 1'b1;
          end
        endcase
      end
      mifd_pkg::CL_BIT: begin
        dec.cls = mifd_pkg::MIFD_CLS_BIT;
        dec.uses_file = 1'b1;
        case (word[11:10])
          2'h0: dec.op = mifd_pkg::MIFD_OP_BCF;
          2'h1: dec.op = mifd_pkg::MIFD_OP_BSF;
          2'h2: dec.op = mifd_pkg::MIFD_OP_BTFSC;
          default: dec.op = mifd_pkg::MIFD_OP_BTFSS;
        endcase
        dec.writes_file = ~word[11];
        dec.cond_skip = word[11];
      end
      mifd_pkg::CL_JUMP: begin
        dec.cls = mifd_pkg::MIFD_CLS_LIT;
        dec.op = word[11] ? mifd_pkg::MIFD_OP_GOTO : mifd_pkg::MIFD_OP_CALL;
        dec.flow_change = 1'b1;
      end
      default: begin
        dec.cls = mifd_pkg::MIFD_CLS_LIT;
        dec.writes_acc = 1'b1;
        casez (word[11:8])
          4'b00??: dec.op = mifd_pkg::MIFD_OP_MOVLW;
          4'b01??: begin
            dec.op = mifd_pkg::MIFD_OP_RETLW;
            dec.flow_change = 1'b1;
          end
          4'b1000: dec.op = mifd_pkg::MIFD_OP_IORLW;
          4'b1001: dec.op = mifd_pkg::MIFD_OP_ANDLW;
          4'b1010: dec.op = mifd_pkg::MIFD_OP_XORLW;
          4'b110?: dec.op = mifd_pkg::MIFD_OP_SUBLW;
          default: dec.op = mifd_pkg::MIFD_OP_ADDLW;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- rtl/mifd_decoder.sv ----
// instruction format decoder with quarter-cycle timing and fetch-alter-store
`timescale 1ns/100ps
`default_nettype none
module mifd_decoder (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [13:0] instr_word,
  input wire logic cond_true,
  output logic cycle_start,
  output logic fetch_strobe,
  output var mifd_pkg::mifd_dec_t dec_out,
  output logic file_rd,
  output logic file_wr,
  output logic acc_wr,
  output logic flag_wr,
  output logic pc_load,
  output logic nop_cycle
);
  // =============================================================
  // quarter counter
  logic [1:0] q_q, q_d;
  always_comb begin
    q_d = q_q + 2'h1;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_q <= mifd_pkg::Q_DECODE;
    end else begin
      q_q <= q_d;
    end
  end

  // =============================================================
  // decode
  if ((1 << $bits(q_q)) != mifd_pkg::QPER) begin : g_quarter_check
    $error("quarter counter cannot span one instruction cycle");
  end
  if ($bits(instr_word) != mifd_pkg::IW) begin : g_word_check
    $error("instruction word width differs from the format");
  end
  mifd_pkg::mifd_dec_t dec_w;
  mifd_field_split u_split (
    .word(instr_word),
    .dec(dec_w)
  );

  typedef enum logic {MIFD_ST_EXEC, MIFD_ST_DUMMY} mifd_state_t;
  mifd_state_t st_q, st_d;
  mifd_pkg::mifd_dec_t dec_q, dec_d;
  logic second_q, second_d;

  function automatic logic two_cycle(input mifd_pkg::mifd_dec_t d,
                                     input logic c);
    two_cycle = d.flow_change | (d.cond_skip & c);
  endfunction

  always_comb begin
    st_d = st_q;
    dec_d = dec_q;
    second_d = second_q;
    // last quarter: settle the skip, then take the next word on the wrap
    if (q_q == mifd_pkg::Q_WRITE) begin
      second_d = 1'b0;
      case (st_q)
        MIFD_ST_EXEC: begin
          if (two_cycle(dec_q, cond_true)) begin
            st_d = MIFD_ST_DUMMY;
            second_d = 1'b1;
            dec_d = '0;
          end else begin
            dec_d = dec_w;
          end
        end
        MIFD_ST_DUMMY: begin
          st_d = MIFD_ST_EXEC;
          dec_d = dec_w;
        end
        default: st_d = MIFD_ST_EXEC;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q <= MIFD_ST_EXEC;
      dec_q <= '0;
      second_q <= 1'b0;
    end else begin
      st_q <= st_d;
      dec_q <= dec_d;
      second_q <= second_d;
    end
  end

  // =============================================================
  // strobes
  logic live;
  logic in_read;
  logic in_write;
  logic cycle_start_d;
  logic fetch_strobe_d;
  logic file_rd_d;
  logic file_wr_d;
  logic acc_wr_d;
  logic flag_wr_d;
  logic pc_load_d;
  logic nop_cycle_d;
  always_comb begin
    in_read = (q_d == mifd_pkg::Q_READ);
    in_write = (q_d == mifd_pkg::Q_WRITE);
    live = dec_q.valid & ~second_q;
    cycle_start_d = (q_d == mifd_pkg::Q_DECODE);
    fetch_strobe_d = in_write;
    nop_cycle_d = second_d;
    file_rd_d = in_read & live & dec_q.uses_file;
    file_wr_d = in_write & live & dec_q.writes_file;
    acc_wr_d = in_write & live & dec_q.writes_acc;
    flag_wr_d = in_write & live & (dec_q.cls != mifd_pkg::MIFD_CLS_BIT)
                & ~dec_q.flow_change;
    pc_load_d = in_write & live & dec_q.flow_change;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cycle_start <= 1'b0;
      fetch_strobe <= 1'b0;
      file_rd <= 1'b0;
      file_wr <= 1'b0;
      acc_wr <= 1'b0;
      flag_wr <= 1'b0;
      pc_load <= 1'b0;
      nop_cycle <= 1'b0;
      dec_out <= '0;
    end else begin
      cycle_start <= cycle_start_d;
      fetch_strobe <= fetch_strobe_d;
      dec_out <= dec_d;
      nop_cycle <= nop_cycle_d;
      file_rd <= file_rd_d;
      file_wr <= file_wr_d;
      acc_wr <= acc_wr_d;
      flag_wr <= flag_wr_d;
      pc_load <= pc_load_d;
    end
  end

  // =============================================================
  // checks
  a_rd_before_wr: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(file_wr) |-> $past(file_rd, 2))
    else $error("file write without prior read");
  a_dummy_quiet: assert property (
    @(posedge clk) disable iff (!nrst)
    nop_cycle |-> !file_wr && !acc_wr && !flag_wr && !pc_load)
    else $error("write during dummy cycle");
  a_quarter_period: assert property (
    @(posedge clk) disable iff (!nrst)
    cycle_start |=> !cycle_start ##1 !cycle_start ##1 !cycle_start
    ##1 cycle_start)
    else $error("instruction cycle not four clocks");
  a_target_acc: assert property (
    @(posedge clk) disable iff (!nrst)
    acc_wr |-> !file_wr)
    else $error("both accumulator and file written");
  a_reg_field: assert property (
    @(posedge clk) disable iff (!nrst)
    dec_w.reg_sel == instr_word[6:0])
    else $error("register field misplaced");
  a_bit_field: assert property (
    @(posedge clk) disable iff (!nrst)
    dec_w.cls == mifd_pkg::MIFD_CLS_BIT |->
    dec_w.pos_sel_in_octet == instr_word[9:7])
    else $error("bit position misplaced");
  a_jump_two: assert property (
    @(posedge clk) disable iff (!nrst)
    pc_load |-> ##1 (!pc_load [*3]) ##1 nop_cycle)
    else $error("jump without dummy cycle");
  a_class_split: assert property (
    @(posedge clk) disable iff (!nrst)
    (instr_word[13:12] == mifd_pkg::CL_BIT) ==
    (dec_w.cls == mifd_pkg::MIFD_CLS_BIT))
    else $error("class decode wrong");
  a_lit_width: assert property (
    @(posedge clk) disable iff (!nrst)
    dec_w.imm11[7:0] == dec_w.imm8)
    else $error("literal fields disagree");
  a_ignored_bits: assert property (
    @(posedge clk) disable iff (!nrst)
    instr_word[13:8] == 6'h01 && !instr_word[7] |->
    dec_w.op == mifd_pkg::MIFD_OP_CLRW)
    else $error("ignored bits affect decode");
  a_word_width: assert property (
    @(posedge clk) disable iff (!nrst)
    cycle_start && dec_out.valid |->
    dec_out.imm11 == 11'($past(instr_word)))
    else $error("decoded word is not the word taken");
  a_rd_quarter: assert property (
    @(posedge clk) disable iff (!nrst)
    file_rd |-> $past(cycle_start))
    else $error("file read outside the read quarter");
  a_wr_quarter: assert property (
    @(posedge clk) disable iff (!nrst)
    file_wr || acc_wr || pc_load |-> fetch_strobe)
    else $error("write outside the write quarter");
  a_fetch_wrap: assert property (
    @(posedge clk) disable iff (!nrst)
    fetch_strobe |=> cycle_start)
    else $error("fetch not followed by a new cycle");
  a_dummy_length: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(nop_cycle) |-> nop_cycle [*4] ##1 !nop_cycle)
    else $error("dummy cycle not one instruction cycle");
  a_skip_taken: assert property (
    @(posedge clk) disable iff (!nrst)
    q_q == mifd_pkg::Q_WRITE && st_q == MIFD_ST_EXEC &&
    dec_q.cond_skip && cond_true |=> nop_cycle)
    else $error("true test without dummy cycle");
  a_skip_kept: assert property (
    @(posedge clk) disable iff (!nrst)
    q_q == mifd_pkg::Q_WRITE && st_q == MIFD_ST_EXEC &&
    !two_cycle(dec_q, cond_true) |=> !nop_cycle)
    else $error("dummy cycle after a one-cycle instruction");
  a_dummy_no_read: assert property (
    @(posedge clk) disable iff (!nrst)
    nop_cycle |-> !file_rd)
    else $error("file read during dummy cycle");
  a_acc_dest: assert property (
    @(posedge clk) disable iff (!nrst)
    acc_wr && dec_out.cls == mifd_pkg::MIFD_CLS_BYTE |->
    !dec_out.result_target)
    else $error("accumulator written with file target");
  a_file_dest: assert property (
    @(posedge clk) disable iff (!nrst)
    file_wr && dec_out.cls == mifd_pkg::MIFD_CLS_BYTE |->
    dec_out.result_target)
    else $error("file written with accumulator target");
  a_pc_flow: assert property (
    @(posedge clk) disable iff (!nrst)
    pc_load |-> dec_out.flow_change)
    else $error("program counter loaded without flow change");
  c_two_cycle: cover property (@(posedge clk) disable iff (!nrst)
    pc_load ##4 nop_cycle);
  c_skip: cover property (@(posedge clk) disable iff (!nrst)
    nop_cycle && dec_out.valid == 1'b0);
  c_file_write: cover property (@(posedge clk) disable iff (!nrst)
    file_wr);
  c_acc_write: cover property (@(posedge clk) disable iff (!nrst)
    acc_wr);
endmodule
`default_nettype wire

// ---- test/mifd_decoder_test.sv ----
// self-checking bench for the instruction format decoder
`timescale 1ns/100ps
`default_nettype none
module mifd_decoder_test;
  logic clk;
  logic nrst;
  logic cond_true;
  logic [13:0] instr_word;
  logic cycle_start, fetch_strobe, file_rd, file_wr, acc_wr, flag_wr;
  logic pc_load, nop_cycle;
  mifd_pkg::mifd_dec_t dec_out;
  mifd_pkg::mifd_dec_t d0;
  int mismatches;
  int n_compared;
  int cycles;

  mifd_decoder dut (
    .clk(clk),
    .nrst(nrst),
    .instr_word(instr_word),
    .cond_true(cond_true),
    .cycle_start(cycle_start),
    .fetch_strobe(fetch_strobe),
    .dec_out(dec_out),
    .file_rd(file_rd),
    .file_wr(file_wr),
    .acc_wr(acc_wr),
    .flag_wr(flag_wr),
    .pc_load(pc_load),
    .nop_cycle(nop_cycle)
  );

  // =============================================================
  // clock, timeout and reporting
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // =============================================================
  // one instruction; e = {rd, wr, acc, flag care, flag, pc, two}
  task automatic exec(input logic [13:0] w, input logic c,
                      input logic [6:0] e, input mifd_pkg::mifd_op_t eo);
    int k;
    mifd_pkg::mifd_class_t cl;
    instr_word = w;
    cond_true = c;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (cycle_start !== 1'b1 && k < 12);
    d0 = dec_out;
    chk("cycle_start", 16'(cycle_start), 16'h1);
    chk("valid nop", 16'({d0.valid, nop_cycle}), 16'h2);
    chk("op", 16'(d0.op), 16'(eo));
    cl = w[13] ? mifd_pkg::MIFD_CLS_LIT :
         (w[12] ? mifd_pkg::MIFD_CLS_BIT : mifd_pkg::MIFD_CLS_BYTE);
    if (eo != mifd_pkg::MIFD_OP_NOP && eo != mifd_pkg::MIFD_OP_CLRW &&
        eo != mifd_pkg::MIFD_OP_CTRL) begin
      chk("class", 16'(d0.cls), 16'(cl));
      case (w[13:12])
        2'h0: chk("tgt reg", 16'({d0.result_target, d0.reg_sel}),
                  16'(w[7:0]));
        2'h1: chk("pos reg", 16'({d0.pos_sel_in_octet, d0.reg_sel}),
                  16'(w[9:0]));
        2'h2: chk("imm11", 16'(d0.imm11), 16'(w[10:0]));
        default: chk("imm8", 16'(d0.imm8), 16'(w[7:0]));
      endcase
    end
    @(negedge clk);
    chk("file_rd", 16'(file_rd), 16'(e[6]));
    @(negedge clk);
    @(negedge clk);
    chk("fetch_strobe", 16'(fetch_strobe), 16'h1);
    chk("file_wr", 16'(file_wr), 16'(e[5]));
    chk("acc_wr", 16'(acc_wr), 16'(e[4]));
    if (e[3]) begin
      chk("flag_wr", 16'(flag_wr), 16'(e[2]));
    end
    chk("pc_load", 16'(pc_load), 16'(e[1]));
    if (e[0]) begin
      instr_word = 14'h3FFF;
      repeat (4) begin
        @(negedge clk);
        chk("dummy", 16'({nop_cycle, dec_out.valid, file_rd | file_wr |
            acc_wr | flag_wr | pc_load}), 16'h4);
      end
    end
  endtask

  // =============================================================
  // scenarios
  task automatic t_reset();
    int k;
    nrst = 1'b0;
    repeat (4) @(negedge clk);
    chk("reset outs", 16'({cycle_start, fetch_strobe, file_rd, file_wr,
        acc_wr, flag_wr, pc_load, nop_cycle, dec_out.valid}), 16'h0);
    nrst = 1'b1;
    for (k = 1; k <= 8; k++) begin
      @(negedge clk);
      chk("cycle_start", 16'(cycle_start), 16'(k == 4 || k == 8));
    end
  endtask

  task automatic t_byte();
    exec(14'h07FF, 0, 7'b1101100, mifd_pkg::MIFD_OP_ADDWF);
    exec(14'h0700, 0, 7'b1011100, mifd_pkg::MIFD_OP_ADDWF);
    exec(14'h01A5, 0, 7'b1101100, mifd_pkg::MIFD_OP_CLRF);
    exec(14'h00C0, 0, 7'b1100000, mifd_pkg::MIFD_OP_MOVWF);
  endtask

  task automatic t_bit();
    exec(14'h1792, 0, 7'b1101000, mifd_pkg::MIFD_OP_BSF);
    exec(14'h107F, 0, 7'b1101000, mifd_pkg::MIFD_OP_BCF);
    exec(14'h1903, 1, 7'b1001001, mifd_pkg::MIFD_OP_BTFSC);
    exec(14'h1E83, 0, 7'b1001000, mifd_pkg::MIFD_OP_BTFSS);
  endtask

  task automatic t_literal();
    exec(14'h30A5, 0, 7'b0010000, mifd_pkg::MIFD_OP_MOVLW);
    exec(14'h33A5, 0, 7'b0010000, mifd_pkg::MIFD_OP_MOVLW);
    exec(14'h2FFF, 0, 7'b0001011, mifd_pkg::MIFD_OP_GOTO);
    exec(14'h2000, 0, 7'b0001011, mifd_pkg::MIFD_OP_CALL);
    exec(14'h345A, 0, 7'b0010011, mifd_pkg::MIFD_OP_RETLW);
    exec(14'h0008, 0, 7'b0000011, mifd_pkg::MIFD_OP_CTRL);
    exec(14'h0009, 0, 7'b0000011, mifd_pkg::MIFD_OP_CTRL);
    exec(14'h3E01, 0, 7'b0011100, mifd_pkg::MIFD_OP_ADDLW);
    exec(14'h3F01, 0, 7'b0011100, mifd_pkg::MIFD_OP_ADDLW);
  endtask

  task automatic t_skip_dontcare();
    exec(14'h0BA0, 1, 7'b1100001, mifd_pkg::MIFD_OP_DECFSZ);
    exec(14'h0F20, 0, 7'b1010000, mifd_pkg::MIFD_OP_INCFSZ);
    exec(14'h0100, 0, 7'b0011100, mifd_pkg::MIFD_OP_CLRW);
    exec(14'h017F, 0, 7'b0011100, mifd_pkg::MIFD_OP_CLRW);
    exec(14'h0060, 0, 7'b0000000, mifd_pkg::MIFD_OP_NOP);
  endtask

  // =============================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    cond_true = 1'b0;
    instr_word = 14'h0000;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    t_reset();
    t_byte();
    t_bit();
    t_literal();
    t_skip_dontcare();
    t_reset();
    exec(14'h0000, 0, 7'b0000000, mifd_pkg::MIFD_OP_NOP);
    finish_test();
  end
endmodule
`default_nettype wire
